/* design/octal_switch_pkg.sv */
package octal_switch_pkg;

  localparam int CHANNELS = 8;
  localparam int CLK_FREQ_KHZ = 10000;

  // Fault qualification window, microseconds
  localparam int FAULT_QUALIFY_TIME_MIN_US = 100;
  localparam int FAULT_QUALIFY_TIME_MAX_US = 300;
  localparam int FAULT_QUALIFY_CYCLES =
    (FAULT_QUALIFY_TIME_MIN_US * CLK_FREQ_KHZ + 999) / 1000;

  // Output switching delays, microseconds
  localparam int OUTPUT_ON_DELAY_MIN_US  = 1;
  localparam int OUTPUT_ON_DELAY_MAX_US  = 50;
  localparam int OUTPUT_OFF_DELAY_MIN_US = 1;
  localparam int OUTPUT_OFF_DELAY_MAX_US = 100;
  localparam int OUTPUT_DELAY_CYCLES =
    (OUTPUT_ON_DELAY_MIN_US * CLK_FREQ_KHZ + 999) / 1000;

  // Host side serial clock divider: half period in core cycles
  localparam int SCLK_HALF_CYCLES = 4;
  // Host spacing between accesses, microseconds (must exceed 300)
  localparam int ACCESS_GAP_US = 310;
  localparam int ACCESS_GAP_CYCLES = (ACCESS_GAP_US * CLK_FREQ_KHZ) / 1000;

  localparam int CNT_W = 16;
  localparam logic [7:0] CMD_RESET = 8'h00;

endpackage

/* design/octal_switch_if.sv */
`timescale 1ns/1ps
interface octal_switch_if;
  logic chip_sel_n;
  logic serial_clk;
  logic serial_cmd_in;
  logic status_out;
  logic status_out_en;

  modport device_end (
    input  chip_sel_n,
    input  serial_clk,
    input  serial_cmd_in,
    output status_out,
    output status_out_en
  );

  modport host_end (
    output chip_sel_n,
    output serial_clk,
    output serial_cmd_in,
    input  status_out,
    input  status_out_en
  );
endinterface

/* design/fault_qualifier.sv */
`timescale 1ns/1ps
// Holds a fault level for a fixed time before reporting it
module fault_qualifier
  import octal_switch_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic fault_raw,
  output logic      fault_flag
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             next_fault_flag;

  // Raw level comes from the analog side; resync before counting
  logic sync_a;
  logic sync_b;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end
    else
    begin
      sync_a <= fault_raw;
      sync_b <= sync_a;
    end
  end

  // Any healthy cycle restarts the qualification
  always_comb
  begin
    next_count      = count;
    next_fault_flag = fault_flag;
    if (!sync_b)
    begin
      next_count      = '0;
      next_fault_flag = 1'b0;
    end
    else if (count >= CNT_W'(FAULT_QUALIFY_CYCLES - 1))
      next_fault_flag = 1'b1; // R13
    else
      next_count = count + CNT_W'(1);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count      <= '0;
      fault_flag <= 1'b0;
    end
    else
    begin
      count      <= next_count;
      fault_flag <= next_fault_flag;
    end
  end

endmodule // fault_qualifier

/* design/octal_switch_device.sv */
`timescale 1ns/1ps
// How it works
// R01 - Chip select high: ignore clock, data, tristate
// R02 - Chip select rise copies shift into outputs
// R03 - Chip select fall loads fault status
// R04 - Drive serial output while chip select low
// R05 - Host keeps clock low at select edges
// R06 - Sample input on clock falling edge
// R07 - Shift toward output on clock rising edge
// R08 - One switches on, zero off, at latch
// R09 - Host sends channel eight first
// R10 - Eight-bit shift register, eight clocks fill
// R11 - Host holds input steady at falling edge
// R12 - Host parks clock low when idle
// R13 - Fault qualified 100 to 300 us
// R14 - Host spaces accesses beyond 300 us
// R15 - Host clock typically 4, max 6 MHz; the host here runs at 1.25 MHz (four core cycles per half period)
// R16 - Outputs follow latch within 1 to 100 us
// R17 - Status one means faulted output
// R18 - First in first out, MSB first
// R19 - Reset clears output latch to zero
module octal_switch_device
  import octal_switch_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  octal_switch_if.device_end link,
  input  wire logic [7:0]    load_fault,
  output logic [7:0]         switch_on,
  output logic [7:0]         fault_status
);

  // Two-stage synchronisers for the three link inputs
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic       cs_n_q;
  logic       sclk_q;

  // Reset to the idle pin levels so no false edge follows reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_a <= 3'h4;
      sync_b <= 3'h4;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
    end
    else
    begin
      sync_a <= {link.chip_sel_n, link.serial_clk, link.serial_cmd_in};
      sync_b <= sync_a;
      cs_n_q <= sync_b[2];
      sclk_q <= sync_b[1];
    end
  end

  logic cs_n;
  logic sclk;
  logic din;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic sclk_rise;

  // Edge detection works on the second stage only
  assign cs_n      = sync_b[2];
  assign sclk      = sync_b[1];
  assign din       = sync_b[0];
  assign cs_fall   = cs_n_q && !cs_n;
  assign cs_rise   = !cs_n_q && cs_n;
  assign sclk_fall = sclk_q && !sclk && !cs_n; // R01 R06
  assign sclk_rise = !sclk_q && sclk && !cs_n; // R01 R07

  // Per-output fault qualification
  logic [7:0] fault_q;

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++)
    begin : g_fault
      fault_qualifier u_fq (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .fault_raw  (load_fault[gi]),
        .fault_flag (fault_q[gi])
      );
    end
  endgenerate

  // Shift path: bit 7 leaves first, input enters at bit 0
  logic [7:0] shift;
  logic       in_bit;
  logic       out_bit;
  logic       out_en;
  logic [7:0] latch;
  logic [7:0] next_shift;
  logic       next_in_bit;
  logic       next_out_bit;
  logic       next_out_en;
  logic [7:0] next_latch;

  // Select edges win over clock edges; the host keeps them apart
  always_comb
  begin
    next_shift   = shift;
    next_in_bit  = in_bit;
    next_out_bit = out_bit;
    next_out_en  = out_en;
    next_latch   = latch;
    if (cs_fall)
    begin
      next_shift   = fault_q;     // R03 R17
      next_in_bit  = 1'b0;        // Drop a bit left from the last frame
      next_out_bit = fault_q[7];  // R18
      next_out_en  = 1'b1;        // R04
    end
    else if (cs_rise)
    begin
      // The last sampled bit still waits for a rise; fold it in here
      // so the latched word is the eight bits of this frame
      next_latch   = {shift[6:0], in_bit};  // R02 R08 R10
      next_out_bit = 1'b0;                  // Park the line between frames
      next_out_en  = 1'b0;                  // R01
    end
    else
    begin
      if (sclk_fall)
        next_in_bit = din;        // R06
      if (sclk_rise)
      begin
        // Sample is held until the rise so the outgoing bit stays
        // valid for a whole clock; eight rises bring in seven bits, the eighth waits in in_bit
        next_shift   = {shift[6:0], in_bit};  // R07 R10 R18
        next_out_bit = shift[6];              // R07
      end
    end
  end

  // Shift path registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift   <= '0;
      in_bit  <= 1'b0;
      out_bit <= 1'b0;
      out_en  <= 1'b0;
      latch   <= CMD_RESET;  // R19
    end
    else
    begin
      shift   <= next_shift;
      in_bit  <= next_in_bit;
      out_bit <= next_out_bit;
      out_en  <= next_out_en;
      latch   <= next_latch;
    end
  end

  // Output switching delay stage, one fixed count after each change;
  // one count serves both directions and meets both minimum delays
  logic [CNT_W-1:0] dly;
  logic [CNT_W-1:0] next_dly;
  logic [7:0]       next_switch_on;

  // Count only while the latch and the outputs differ
  always_comb
  begin
    next_dly       = dly;
    next_switch_on = switch_on;
    if (latch != switch_on)
    begin
      if (dly >= CNT_W'(OUTPUT_DELAY_CYCLES - 1))
      begin
        next_switch_on = latch;  // R16
        next_dly       = '0;
      end
      else
        next_dly = dly + CNT_W'(1);
    end
    else
      next_dly = '0;
  end

  // Delay and outputs; every output comes straight from a flop
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dly          <= '0;
      switch_on    <= CMD_RESET;  // R19
      fault_status <= '0;
    end
    else
    begin
      dly          <= next_dly;
      switch_on    <= next_switch_on;
      fault_status <= fault_q;    // R17
    end
  end

  // Enable marks a driven line; the far end ignores it otherwise
  assign link.status_out    = out_bit;
  assign link.status_out_en = out_en;

endmodule // octal_switch_device

/* design/octal_switch_host.sv */
`timescale 1ns/1ps
// Host end: sends one eight-bit command, returns the status word
module octal_switch_host
  import octal_switch_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  octal_switch_if.host_end link,
  input  wire logic        start,
  input  wire logic [7:0]  cmd,
  output logic             busy,
  output logic             done,
  output logic [7:0]       status
);

  typedef enum logic [3:0] {
    IDLE  = 4'b0001,
    LEAD  = 4'b0010,
    XFER  = 4'b0100,
    GAP   = 4'b1000
  } state_type;

  state_type        state;
  state_type        next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [3:0]       bits;
  logic [3:0]       next_bits;
  logic [7:0]       tx;
  logic [7:0]       next_tx;
  logic [7:0]       rx;
  logic [7:0]       next_rx;
  logic             cs_n;
  logic             next_cs_n;
  logic             sclk;
  logic             next_sclk;
  logic             next_busy;
  logic             next_done;
  logic [7:0]       next_status;
  logic             so_a;
  logic             so_b;

  // Status line is from the device; two flops first
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      so_a <= 1'b0;
      so_b <= 1'b0;
    end
    else
    begin
      so_a <= link.status_out;
      so_b <= so_a;
    end
  end

  // Clock divides core clock; data changes one core cycle after the fall,
  // after the device's falling sample, and clock idles low around select edges
  always_comb
  begin
    next_state  = state;
    next_cnt    = cnt;
    next_bits   = bits;
    next_tx     = tx;
    next_rx     = rx;
    next_cs_n   = cs_n;
    next_sclk   = sclk;
    next_busy   = busy;
    next_done   = 1'b0;
    next_status = status;
    case (state)
      IDLE:
      begin
        next_sclk = 1'b0;  // R12
        if (start)
        begin
          next_tx    = cmd;
          next_cs_n  = 1'b0;  // R05
          next_busy  = 1'b1;
          next_cnt   = '0;
          next_bits  = '0;
          next_state = LEAD;
        end
      end
      LEAD:
      begin
        // Sync delay in the device plus lead time
        if (cnt >= CNT_W'(SCLK_HALF_CYCLES * 2 - 1))
        begin
          next_cnt   = '0;
          next_state = XFER;
        end
        else
          next_cnt = cnt + CNT_W'(1);
      end
      XFER:
      begin
        if (cnt >= CNT_W'(SCLK_HALF_CYCLES - 1))
        begin
          next_cnt = '0;
          if (!sclk)
          begin
            if (bits == 4'h8)
            begin
              next_cs_n   = 1'b1;  // R05
              next_status = rx;
              next_done   = 1'b1;
              next_state  = GAP;
            end
            else
            begin
              next_sclk = 1'b1;
              next_rx   = {rx[6:0], so_b};
            end
          end
          else
          begin
            next_sclk = 1'b0;          // R11
            next_bits = bits + 4'h1;
          end
        end
        else
          next_cnt = cnt + CNT_W'(1);
      end
      GAP:
      begin
        if (cnt >= CNT_W'(ACCESS_GAP_CYCLES - 1))  // R14
        begin
          next_busy  = 1'b0;
          next_state = IDLE;
        end
        else
          next_cnt = cnt + CNT_W'(1);
      end
      default:
        next_state = IDLE;
    endcase
  end

  // Data bit presented while clock low; channel eight first
  logic data_bit;
  assign data_bit = tx[3'(7 - bits[2:0])];  // R09 R15

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state  <= IDLE;
      cnt    <= '0;
      bits   <= '0;
      tx     <= '0;
      rx     <= '0;
      cs_n   <= 1'b1;
      sclk   <= 1'b0;
      busy   <= 1'b0;
      done   <= 1'b0;
      status <= '0;
    end
    else
    begin
      state  <= next_state;
      cnt    <= next_cnt;
      bits   <= next_bits;
      tx     <= next_tx;
      rx     <= next_rx;
      cs_n   <= next_cs_n;
      sclk   <= next_sclk;
      busy   <= next_busy;
      done   <= next_done;
      status <= next_status;
    end
  end

  logic din_q;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      din_q <= 1'b0;
    else
      din_q <= (state == XFER && bits < 4'h8) ? data_bit : 1'b0;
  end

  assign link.chip_sel_n    = cs_n;
  assign link.serial_clk    = sclk;
  assign link.serial_cmd_in = din_q;

endmodule // octal_switch_host

/* test/octal_switch_serial_chk.sv */
`timescale 1ns/1ps
// Watches the serial link between the host and device ends
module octal_switch_serial_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic chip_sel_n,
  input wire logic serial_clk,
  input wire logic serial_cmd_in,
  input wire logic status_out,
  input wire logic status_out_en
);
  logic [3:0] rise_cnt;
  logic [3:0] next_rise_cnt;
  logic       clk_q;
  logic       next_clk_q;

  // Clock rises per frame; cleared while deselected
  always_comb
  begin
    next_clk_q    = serial_clk;
    next_rise_cnt = rise_cnt;
    if (chip_sel_n)
      next_rise_cnt = 4'h0;
    else if (serial_clk && !clk_q)
      next_rise_cnt = rise_cnt + 4'h1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rise_cnt <= 4'h0;
      clk_q    <= 1'b0;
    end
    else
    begin
      rise_cnt <= next_rise_cnt;
      clk_q    <= next_clk_q;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Enable may trail the select edge by the input synchroniser
  a_idle_output_off: assert property (
    chip_sel_n [*5] |-> !status_out_en) else $error("output on when idle");
  a_select_drives: assert property (
    !chip_sel_n [*5] |-> status_out_en) else $error("output off in frame");
  a_enable_prompt: assert property (
    $fell(chip_sel_n) |-> ##[1:4] status_out_en) else $error("enable late");
  a_clk_low_edge: assert property (
    $changed(chip_sel_n) |-> !serial_clk) else $error("clock high at edge");
  a_clk_parked: assert property (
    chip_sel_n |-> !serial_clk) else $error("clock not parked");
  a_clk_rate: assert property (
    $rose(serial_clk) |-> serial_clk [*4] ##1 !serial_clk)
    else $error("clock high time wrong");
  a_data_hold: assert property (
    $fell(serial_clk) |-> $stable(serial_cmd_in)) else $error("data moved");
  a_status_steady: assert property (
    !chip_sel_n && $fell(serial_clk) |-> $stable(status_out))
    else $error("status moved at fall");
  a_eight_clocks: assert property (
    $rose(chip_sel_n) |-> rise_cnt == 4'h8) else $error("not eight clocks");

  c_frame_end: cover property ($rose(chip_sel_n));
  c_drive_on: cover property ($rose(status_out_en));
  c_status_one: cover property (!chip_sel_n && status_out);
endmodule // octal_switch_serial_chk

/* test/tb_octal_switch_serial_control.sv */
`timescale 1ns/1ps
module tb_octal_switch_serial_control;
  logic       core_clk;
  logic       rst_n;
  logic       start;
  logic [7:0] cmd;
  logic [7:0] load_fault;
  logic       busy;
  logic       done;
  logic [7:0] status;
  logic [7:0] switch_on;
  logic [7:0] fault_status;
  logic [7:0] got;
  logic [7:0] prev;
  logic [7:0] lf;
  int         error_cnt;
  int         samples_checked;
  logic [7:0] cmds [6] = '{8'ha5, 8'h5a, 8'hff, 8'h00, 8'h80, 8'h01};
  logic [7:0] flts [6] = '{8'h3c, 8'h00, 8'hff, 8'h55, 8'haa, 8'h00};

  octal_switch_if link ();

  octal_switch_host u_octal_switch_host (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .link     (link),
    .start    (start),
    .cmd      (cmd),
    .busy     (busy),
    .done     (done),
    .status   (status)
  );

  octal_switch_device u_octal_switch_device (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .link         (link),
    .load_fault   (load_fault),
    .switch_on    (switch_on),
    .fault_status (fault_status)
  );

  octal_switch_serial_chk u_octal_switch_serial_chk (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .chip_sel_n    (link.chip_sel_n),
    .serial_clk    (link.serial_clk),
    .serial_cmd_in (link.serial_cmd_in),
    .status_out    (link.status_out),
    .status_out_en (link.status_out_en)
  );

  // 10 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic end_of_test();
    $display("Checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // A hang counts as a mismatch and closes the run
  task automatic timeout();
    error_cnt++;
    $display("Error t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end_of_test();
  endtask

  // One host access; waits for done only, the host's GAP state keeps the next access over 300 us away
  task automatic xfer(input logic [7:0] c);
    int n;
    cmd   = c;
    start = 1'b1;
    cycles(1);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 200)
    begin
      cycles(1);
      n++;
    end
    if (n == 200)
      timeout();
    got = status;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 4000)
    begin
      cycles(1);
      n++;
    end
    if (n == 4000)
      timeout();
  endtask

  // Reset, fault qualification, then a table of commands
  initial
  begin
    rst_n = 1'b0;
    start = 1'b0;
    cmd = 8'h00;
    load_fault = 8'h81;
    error_cnt = 0;
    samples_checked = 0;
    prev = 8'h00;
    cycles(6);
    rst_n = 1'b1;
    cycles(2);
    chk(switch_on, 8'h00);
    cycles(900);
    chk(fault_status, 8'h00);
    cycles(300);
    chk(fault_status, 8'h81);
    lf = 8'h81;
    for (int i = 0; i < 6; i++)
    begin
      xfer(cmds[i]);
      chk(got, lf);
      chk(switch_on, prev);
      load_fault = flts[i];
      cycles(500);
      chk(switch_on, cmds[i]);
      wait_idle();
      prev = cmds[i];
      lf = flts[i];
    end
    end_of_test();
  end
endmodule // tb_octal_switch_serial_control
